// *** axi_lite_host.sv ***
// host model: one axi4-lite master issuing single reads and writes
// assumes the slave answers in its own time; the bench watchdog cuts hangs
`timescale 1ns/1ns
`default_nettype none

module axi_lite_host
    import poe_status_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // write side
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus from time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
        {araddr, arvalid, rready} <= '0;
    end

    // both halves offered together, each dropped once taken
    task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk_sys);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    // address held until taken, data captured with rvalid
    task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk_sys);
            if (arvalid && arready)
                arvalid <= 1'h0;
        end
        while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask
endmodule

`default_nettype wire

// *** poe_discovery_status.sv ***
// discovery and power status register bank for four power channels
// assumes detection, classification and turn-on engines drive the
// channel inputs synchronously to clk_sys; host uses axi4-lite
//
// How it works
// - channel 4 discovery byte at index 0x0F
// - channel off clears class and detect fields
// - class codes 0-7; 0101 reads as class 0
// - class codes 8-15 stored as measured
// - detect field holds latest detection result
// - class>=4 powered at 15.5 W reads 4+
// - single signature: post both, flag measured only
// - dual signature: each channel posts own class
// - class 0 load powered gets assigned class 3
// - manual, one class enable: class 8 -> 5DS
// - requested class kept apart from assigned class
// - power status byte at index 0x10
// - power good latched until off or reset
// - power enabled mirrors channel on state
// - off, even by fault, clears power bits
// - 2-pair and dual signature ports update channels independently
// - single signature: power good after both channels
// - dual signature: change events per channel
// - channels 1 to 3 at 0x0C to 0x0E
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module poe_discovery_status
    import poe_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // channel control state from the sequencer
    input wire logic [NUM_CH-1:0] modeOff,
    input wire logic [NUM_CH-1:0] classEnable,
    input wire logic [NUM_CH-1:0] powerOn,
    input wire logic [NUM_CH-1:0] channelDrainSense,
    // classification and detection engine results
    input wire logic [NUM_CH-1:0] classDone,
    input wire logic [NUM_CH-1:0][3:0] classCode,
    input wire logic [NUM_CH-1:0] detDone,
    input wire logic [NUM_CH-1:0][3:0] detCode,
    // results to the rest of the device
    output logic [NUM_CH-1:0][3:0] assignedClass,
    output evt_s events
);

    // ************************************************************
    // state
    // ************************************************************
    logic [NUM_CH-1:0][3:0] requestedClassField;  // most recent requested class
    logic [NUM_CH-1:0][3:0] detectField;          // most recent detection result
    logic [NUM_CH-1:0] powerGoodFlags;             // latched power good
    logic [NUM_CH-1:0] powerEnabledFlags;          // channel on state
    cfg_s cfg;                                     // software steering bits

    // next values computed per channel
    logic [NUM_CH-1:0][3:0] next_requestedClass;
    logic [NUM_CH-1:0][3:0] next_detect;
    logic [NUM_CH-1:0][3:0] next_assigned;
    logic [NUM_CH-1:0] next_powerGood;
    logic [NUM_CH-1:0] pgCandidate;               // channel would be good on its own

    // ************************************************************
    // per channel discovery and power status logic
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            localparam int PARTNER = ch ^ 1;
            localparam int PAIR = ch / 2;

            // load type of the port this channel belongs to
            wire isFourPair = cfg.fourPair[PAIR];
            wire isSingleSig = isFourPair & ~cfg.dualSig[PAIR];

            // single signature: partner's measurement is posted here too
            wire postOwn = classDone[ch];
            wire postPartner = isSingleSig & classDone[PARTNER] & ~classDone[ch];
            wire postAny = postOwn | postPartner;
            wire [3:0] rawClass = postOwn ? classCode[ch] : classCode[PARTNER];

            // class enabled on only one channel of the pair
            wire oneSided = isFourPair & (classEnable[ch] ^ classEnable[PARTNER]);
            wire fiveDs = cfg.manualMode[ch] & oneSided & (rawClass == CLS_8_SS);

            // reserved code reads back as class 0
            wire [3:0] fixedClass = (rawClass == CLS_RSV_AS0) ? CLS_0 :
                                    fiveDs ? CLS_5_DS :
                                    rawClass;

            // rising edge of the on state marks a power-up
            wire poweringUp = powerOn[ch] & ~powerEnabledFlags[ch];

            // class 4 or higher, single or dual signature, counted as high
            wire [3:0] curClass = postAny ? fixedClass : requestedClassField[ch];
            wire highClass = (curClass == CLS_4) |
                             ((curClass >= CLS_5_SS) & (curClass <= CLS_8_SS)) |
                             (curClass == CLS_5_DS);
            wire limitTo4p = poweringUp & cfg.alloc15w[ch] & highClass;

            // requested class: off clears first, then limit, then new or held result
            assign next_requestedClass[ch] = modeOff[ch] ? CLS_UNKNOWN :
                                             limitTo4p ? CLS_4P_T1LIM :
                                             curClass;

            // detection result simply replaced on each new result
            assign next_detect[ch] = modeOff[ch] ? DET_UNKNOWN :
                                     detDone[ch] ? detCode[ch] :
                                     detectField[ch];

            // assigned class is its own register, fixed at power-up
            assign next_assigned[ch] = ~powerOn[ch] ? CLS_UNKNOWN :
                                       ~poweringUp ? assignedClass[ch] :
                                       (curClass == CLS_0) ? CLS_3 :
                                       limitTo4p ? CLS_4P_T1LIM :
                                       curClass;

            // drain fell below the threshold while the channel is on
            assign pgCandidate[ch] = powerOn[ch] & (powerGoodFlags[ch] | channelDrainSense[ch]);

            // single signature waits for the partner so both channels' events fire in the same cycle
            wire partnerOk = ~isSingleSig | pgCandidate[PARTNER];
            assign next_powerGood[ch] = powerOn[ch] &
                                        (powerGoodFlags[ch] |
                                         (channelDrainSense[ch] & partnerOk));

            // discovery and power registers, cleared only by reset or off
            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    requestedClassField[ch] <= DISC_RESET[CLASS_LSB +: 4];
                    detectField[ch] <= DISC_RESET[DETECT_LSB +: 4];
                    assignedClass[ch] <= CLS_UNKNOWN;
                    powerGoodFlags[ch] <= POWER_RESET[PG_LSB + ch];
                    powerEnabledFlags[ch] <= POWER_RESET[PE_LSB + ch];
                end
                else
                begin
                    requestedClassField[ch] <= next_requestedClass[ch];
                    detectField[ch] <= next_detect[ch];
                    assignedClass[ch] <= next_assigned[ch];
                    powerGoodFlags[ch] <= next_powerGood[ch];
                    powerEnabledFlags[ch] <= powerOn[ch];
                end
            end

            // change events, one cycle each, driven from flip-flops
            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    events.classComplete[ch] <= 1'b0;
                    events.powerEnableChange[ch] <= 1'b0;
                    events.powerGoodChange[ch] <= 1'b0;
                end
                else
                begin
                    // only the measuring channel flags completion
                    events.classComplete[ch] <= postOwn & ~modeOff[ch];
                    events.powerEnableChange[ch] <= powerOn[ch] ^ powerEnabledFlags[ch];
                    events.powerGoodChange[ch] <= next_powerGood[ch] ^ powerGoodFlags[ch];
                end
            end
        end
    endgenerate

    // ************************************************************
    // register decode
    // ************************************************************
    // printed offsets are indices; low two address bits are ignored
    wire [7:0] rdIndex = araddr[9:2];
    wire rdInRange = (araddr[ADDR_W-1:10] == '0);
    wire rdIsDisc = rdInRange & (rdIndex >= IDX_DISC_CH1) & (rdIndex <= IDX_DISC_CH4);
    wire rdIsPower = rdInRange & (rdIndex == IDX_POWER);
    wire rdIsConfig = rdInRange & (rdIndex == IDX_CONFIG);
    wire [1:0] rdChan = 2'(rdIndex - IDX_DISC_CH1);
    wire [7:0] discByte = {requestedClassField[rdChan], detectField[rdChan]};
    wire [7:0] powerByte = {powerGoodFlags, powerEnabledFlags};
    wire [31:0] readWord = rdIsDisc ? {24'h00_0000, discByte} :
                           rdIsPower ? {24'h00_0000, powerByte} :
                           rdIsConfig ? {20'h0_0000, cfg} :
                           32'h0000_0000;
    wire rdOk = rdIsDisc | rdIsPower | rdIsConfig;

    // ************************************************************
    // axi4-lite write path
    // ************************************************************
    logic awHeld;                  // write address captured
    logic wHeld;                   // write data captured
    logic [ADDR_W-1:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;

    // accept each half once; nothing new until the response is taken
    assign awready = ~awHeld & ~bvalid;
    assign wready = ~wHeld & ~bvalid;

    wire [7:0] wrIndex = awAddrHeld[9:2];
    wire wrInRange = (awAddrHeld[ADDR_W-1:10] == '0);
    wire wrIsConfig = wrInRange & (wrIndex == IDX_CONFIG);
    // status registers are read only: accepted, answered, not stored
    wire wrIsStatus = wrInRange & ((wrIndex >= IDX_DISC_CH1) & (wrIndex <= IDX_POWER));
    wire wrFire = awHeld & wHeld & ~bvalid;

    // byte enables apply to the two low lanes of the config word
    wire [11:0] cfgMerged = {wStrbHeld[1] ? wDataHeld[11:8] : cfg[11:8],
                             wStrbHeld[0] ? wDataHeld[7:0] : cfg[7:0]};

    // capture halves, then answer both together
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= '0;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            cfg <= CONFIG_RESET;
        end
        else
        begin
            if (awvalid & awready)
            begin
                awHeld <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid & wready)
            begin
                wHeld <= 1'b1;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (wrFire)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wrIsConfig | wrIsStatus) ? RESP_OKAY : RESP_SLVERR;
                if (wrIsConfig)
                begin
                    cfg <= cfgMerged;
                end
            end
            else if (bvalid & bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // axi4-lite read path
    // ************************************************************
    // one read outstanding; data sampled in the accepting cycle
    assign arready = ~rvalid;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid & arready)
        begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid & rready)
        begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** poe_status_pkg.sv ***
// package for the channel discovery and power status register bank
// assumes a 100 MHz core clock and an axi4-lite host with 32-bit data
package poe_status_pkg;

    // ************************************************************
    // channel count and bus geometry
    // ************************************************************
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 12;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_DISC_CH1 = 8'h0C;
    localparam logic [7:0] IDX_DISC_CH4 = 8'h0F;
    localparam logic [7:0] IDX_POWER = 8'h10;
    localparam logic [7:0] IDX_CONFIG = 8'h20;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CLASS_LSB = 4;
    localparam int DETECT_LSB = 0;
    localparam int PG_LSB = 4;
    localparam int PE_LSB = 0;
    localparam logic [7:0] DISC_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [11:0] CONFIG_RESET = 12'h000;

    // ************************************************************
    // requested class codes
    // ************************************************************
    localparam logic [3:0] CLS_UNKNOWN = 4'h0;
    localparam logic [3:0] CLS_3 = 4'h3;
    localparam logic [3:0] CLS_4 = 4'h4;
    localparam logic [3:0] CLS_RSV_AS0 = 4'h5;
    localparam logic [3:0] CLS_0 = 4'h6;
    localparam logic [3:0] CLS_OVERCUR = 4'h7;
    localparam logic [3:0] CLS_5_SS = 4'h8;
    localparam logic [3:0] CLS_8_SS = 4'hB;
    localparam logic [3:0] CLS_4P_T1LIM = 4'hC;
    localparam logic [3:0] CLS_5_DS = 4'hD;
    localparam logic [3:0] CLS_RSV = 4'hE;
    localparam logic [3:0] CLS_MISMATCH = 4'hF;

    // ************************************************************
    // detection result codes
    // ************************************************************
    localparam logic [3:0] DET_UNKNOWN = 4'h0;
    localparam logic [3:0] DET_SHORT = 4'h1;
    localparam logic [3:0] DET_TOO_LOW = 4'h3;
    localparam logic [3:0] DET_VALID = 4'h4;
    localparam logic [3:0] DET_TOO_HIGH = 4'h5;
    localparam logic [3:0] DET_OPEN = 4'h6;
    localparam logic [3:0] DET_FET_FAULT = 4'hE;

    // ************************************************************
    // timing: class posting deadline and the derived cycle budget
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int POST_LIMIT_MS = 5;
    localparam int POST_LIMIT_CYC = POST_LIMIT_MS * 1000 * CLK_MHZ;

    // ************************************************************
    // axi response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // configuration register layout, low 12 bits of the word
    typedef struct packed {
        logic [3:0] manualMode;    // per channel manual/diagnostic mode
        logic [3:0] alloc15w;      // per channel 15.5 W allocation
        logic [1:0] dualSig;       // per port pair: dual signature load
        logic [1:0] fourPair;      // per port pair: wired as 4-pair
    } cfg_s;

    // per channel event pulses
    typedef struct packed {
        logic [3:0] classComplete;
        logic [3:0] powerEnableChange;
        logic [3:0] powerGoodChange;
    } evt_s;

endpackage

// *** poe_status_props.sv ***
// checker for the status register bank, watching only its ports
// assumes it is bound onto poe_discovery_status with one clock domain
`timescale 1ns/1ns
`default_nettype none

module poe_status_props
    import poe_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bus handshakes
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // channel side
    input wire logic [NUM_CH-1:0] modeOff,
    input wire logic [NUM_CH-1:0] powerOn,
    input wire logic [NUM_CH-1:0] classDone,
    input wire logic [NUM_CH-1:0][3:0] assignedClass,
    input wire evt_s events
);
    // ************************************************************
    // one clock domain, reset disables everything
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // read answered one cycle after the address is taken
    property p_rd_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    // read data stands until the host takes it
    property p_rd_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // no new read while one is outstanding
    property p_ar_block;
        rvalid |-> !arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted twice");
    // write answer stands until taken
    property p_b_hold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    // both write halves refused while answer pending
    property p_w_block;
        bvalid |-> !awready && !wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write accepted early");
    // class result flagged on the measured channel
    property p_cls_post;
        classDone[0] && !modeOff[0] |=> events.classComplete[0];
    endproperty
    a_cls_post: assert property (p_cls_post) else $error("class complete missing");
    // a channel held off posts nothing
    property p_cls_off;
        classDone[3] && modeOff[3] |=> !events.classComplete[3];
    endproperty
    a_cls_off: assert property (p_cls_off) else $error("class flagged while off");
    // turn-on shows as an enable change one cycle later
    property p_pe_event;
        $rose(powerOn[1]) |=> events.powerEnableChange[1];
    endproperty
    a_pe_event: assert property (p_pe_event) else $error("enable change missing");
    // assigned class kept apart and empty while unpowered
    property p_assigned_off;
        !powerOn[2] ##1 !powerOn[2] |-> assignedClass[2] == 4'h0;
    endproperty
    a_assigned_off: assert property (p_assigned_off) else $error("assigned class while off");
endmodule

bind poe_discovery_status poe_status_props i_poe_status_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .modeOff(modeOff),
    .powerOn(powerOn), .classDone(classDone), .assignedClass(assignedClass), .events(events));

`default_nettype wire

// *** tb_poe_discovery_status.sv ***
// self-checking bench for the discovery and power status bank
// assumes the host model drives the bus; channel inputs driven here
`timescale 1ns/1ns
`default_nettype none

module tb_poe_discovery_status
    import poe_status_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb, cc;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [NUM_CH-1:0] modeOff = '0, classEnable = '0, powerOn = '0, drain = '0, classDone = '0, detDone = '0;
    logic [NUM_CH-1:0][3:0] classCode = '0, detCode = '0, assignedClass;
    evt_s events;
    int n_fail = 0, checks = 0;

    always #5 clk_sys = ~clk_sys;
    poe_discovery_status i_poe_discovery_status (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .modeOff(modeOff), .classEnable(classEnable), .powerOn(powerOn),
        .channelDrainSense(drain), .classDone(classDone), .classCode(classCode), .detDone(detDone),
        .detCode(detCode), .assignedClass(assignedClass), .events(events));
    axi_lite_host i_axi_lite_host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // register read by index, answer must be okay
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        i_axi_lite_host.read({2'h0, idx, 2'h0}, got, resp);
        chk(got, 32'(e));
        chk(32'(resp), 32'(RESP_OKAY));
    endtask
    task automatic wrc(input logic [7:0] idx, input logic [31:0] d);
        i_axi_lite_host.write({2'h0, idx, 2'h0}, d, resp);
        chk(32'(resp), 32'(RESP_OKAY));
    endtask
    // one engine result; cc catches the registered class flags
    task automatic pulse(input int ch, input logic [3:0] c, input logic [3:0] d);
        @(posedge clk_sys);
        classDone[ch] <= 1'h1;
        classCode[ch] <= c;
        detDone[ch] <= 1'h1;
        detCode[ch] <= d;
        @(posedge clk_sys);
        classDone <= '0;
        detDone <= '0;
        @(posedge clk_sys);
        cc = events.classComplete;
    endtask
    // all channels off for two cycles, clears state between tests
    task automatic all_off();
        @(posedge clk_sys);
        {modeOff, powerOn, drain, classEnable} <= {4'hf, 12'h000};
        repeat (2) @(posedge clk_sys);
        modeOff <= '0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_map();
        for (int i = 12; i <= 16; i++)
            rdc(8'(i), 8'h00);
        i_axi_lite_host.read(12'h044, got, resp);
        chk(32'(resp), 32'(RESP_SLVERR));
        $display("test map done");
    endtask
    task automatic t_codes();
        logic [3:0] dets [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'he};
        for (int c = 0; c < 16; c++)
        begin
            pulse(3, 4'(c), dets[c % 7]);
            chk(32'(cc), 32'h0000_0008);
            rdc(8'h0f, {(c == 5) ? CLS_0 : 4'(c), dets[c % 7]});
        end
        wrc(8'h0f, 32'hffff_ffff);
        rdc(8'h0f, {CLS_MISMATCH, DET_SHORT});
        wrc(8'h10, 32'hffff_ffff);
        rdc(8'h10, 8'h00);
        $display("test codes done");
    endtask
    task automatic t_off();
        modeOff[3] <= 1'h1;
        rdc(8'h0f, 8'h00);
        pulse(3, CLS_4, DET_VALID);
        chk(32'(cc), 32'h0000_0000);
        rdc(8'h0f, 8'h00);
        all_off();
        $display("test off done");
    endtask
    task automatic t_power();
        {powerOn[0], drain[0]} <= 2'h3;
        rdc(8'h10, 8'h11);
        {powerOn[1], drain[0]} <= 2'h2;
        rdc(8'h10, 8'h13);
        powerOn[0] <= 1'h0;
        rdc(8'h10, 8'h02);
        all_off();
        $display("test power done");
    endtask
    task automatic t_single();
        wrc(8'h20, 32'h0000_0001);
        pulse(0, CLS_4, DET_VALID);
        chk(32'(cc), 32'h0000_0001);
        rdc(8'h0d, 8'h40);
        {powerOn[0], drain[0]} <= 2'h3;
        rdc(8'h10, 8'h01);
        {powerOn[1], drain[1]} <= 2'h3;
        rdc(8'h10, 8'h33);
        all_off();
        $display("test single done");
    endtask
    task automatic t_limit();
        wrc(8'h20, 32'h0000_0040);
        pulse(2, CLS_4, DET_VALID);
        powerOn[2] <= 1'h1;
        rdc(8'h0e, {CLS_4P_T1LIM, DET_VALID});
        pulse(3, CLS_0, DET_VALID);
        powerOn[3] <= 1'h1;
        rdc(8'h0f, {CLS_0, DET_VALID});
        chk(32'(assignedClass[3]), 32'(CLS_3));
        all_off();
        wrc(8'h20, 32'h0000_0101);
        classEnable <= 4'h1;
        pulse(0, CLS_8_SS, DET_VALID);
        rdc(8'h0c, {CLS_5_DS, DET_VALID});
        wrc(8'h20, 32'h0000_0005);
        pulse(1, CLS_3, DET_VALID);
        rdc(8'h0c, {CLS_5_DS, DET_VALID});
        all_off();
        $display("test limit done");
    endtask

    // ************************************************************
    // run control
    // ************************************************************
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("mismatch %0t: timeout", $time);
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        t_map();
        t_codes();
        t_off();
        t_power();
        t_single();
        t_limit();
        wrap_up();
    end
endmodule

`default_nettype wire
